// ---- hdl/twa_arbiter_end.sv ----
// Purpose: External arbiter end sharing the bus between the processor and one other master
// Assumes: Other master's activity is a user-side level, released one cycle before grant
// Notes: Grant is withdrawn as soon as the other master asks, even while the device is mid-cycle
`timescale 1ns/10ps
module twa_arbiter_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link
  twa_link_if.arbiter_end link,
  // Other master and device grant status on the user side
  input wire logic otherRequest,
  output logic otherGrant,
  output logic deviceGranted
);
  twa_pkg::twa_arb_t state, next_state;
  logic next_otherGrant;
  logic next_deviceGranted;
  logic grantN, next_grantN;
  logic [2:0] holdCount, next_holdCount;

  assign link.busGrantN = grantN;

  always_comb
  begin
    next_state = state;
    next_otherGrant = otherGrant;
    next_grantN = grantN;
    next_holdCount = holdCount;
    case (state)
      twa_pkg::AR_OTHER:
      begin
        if (holdCount != 3'h0)
        begin
          next_holdCount = holdCount - 3'h1;
        end
        // Release other master a cycle before granting the device
        if (!otherRequest || (holdCount == 3'h0 && link.busRequestN == twa_pkg::PIN_ASSERTED))
        begin
          if (link.busRequestN == twa_pkg::PIN_ASSERTED || !otherRequest)
          begin
            next_otherGrant = 1'b0;
            next_state = twa_pkg::AR_GAP;
          end
        end
      end
      twa_pkg::AR_GAP:
      begin
        next_grantN = twa_pkg::PIN_ASSERTED;
        next_state = twa_pkg::AR_DEVICE;
      end
      twa_pkg::AR_DEVICE:
      begin
        // Withdraw grant early so the device releases after its cycle
        if (otherRequest)
        begin
          next_grantN = twa_pkg::PIN_NEGATED;
        end
        if (grantN == twa_pkg::PIN_NEGATED && link.busBusyN == twa_pkg::PIN_NEGATED)
        begin
          next_otherGrant = 1'b1;
          next_holdCount = 3'(twa_pkg::OTHER_HOLD_CYCLES);
          next_state = twa_pkg::AR_OTHER;
        end
      end
      default:
      begin
        next_state = twa_pkg::AR_OTHER;
      end
    endcase
    next_deviceGranted = (next_grantN == twa_pkg::PIN_ASSERTED);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= twa_pkg::AR_OTHER;
      otherGrant <= 1'b0;
      grantN <= twa_pkg::PIN_NEGATED;
      holdCount <= 3'h0;
      deviceGranted <= 1'b0;
    end
    else
    begin
      state <= next_state;
      otherGrant <= next_otherGrant;
      grantN <= next_grantN;
      holdCount <= next_holdCount;
      deviceGranted <= next_deviceGranted;
    end
  end
endmodule

// ---- hdl/twa_device_end.sv ----
// Purpose: Processor end of three-wire bus arbitration with a simple cycle engine
// Assumes: Core holds coreRequest and its address until coreStart pulses
// Notes: A cycle spans burstBeats+1 acknowledges; bus error also ends it
`timescale 1ns/10ps
module twa_device_end #(
  parameter int ADDR_WIDTH = twa_pkg::ADDR_WIDTH,
  parameter int BEAT_WIDTH = twa_pkg::BEAT_WIDTH
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic watchdogReset,
  // Link
  twa_link_if.device_end link,
  // Core side
  input wire logic coreRequest,
  input wire logic [ADDR_WIDTH-1:0] coreAddr,
  input wire logic [BEAT_WIDTH-1:0] burstBeats,
  input wire logic busError,
  output logic coreStart,
  output logic coreDone,
  output twa_pkg::twa_state_t arbState
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  twa_pkg::twa_state_t next_arbState;
  logic inCycle, next_inCycle;
  logic [BEAT_WIDTH-1:0] beatsLeft, next_beatsLeft;
  logic [ADDR_WIDTH-1:0] addrHold, next_addrHold;
  logic requestN, next_requestN;
  logic busyN, next_busyN;
  logic startPinN, next_startPinN;
  logic strobePinN, next_strobePinN;
  logic drive, next_drive;
  logic next_coreStart;
  logic next_coreDone;
  logic granted;
  logic endOfCycle;
  logic startNow;

  function automatic logic isAsserted(input logic pinN);
    isAsserted = (pinN == twa_pkg::PIN_ASSERTED);
  endfunction

  // Only grant, own request and own transfer state steer arbitration
  assign granted = isAsserted(link.busGrantN);
  // Normal termination of the last beat, or a bus error on any beat, ends the cycle
  assign endOfCycle = inCycle && (busError || (isAsserted(link.transferAckN) && beatsLeft == '0));

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_arbState = arbState;
    startNow = 1'b0;
    case (arbState)
      twa_pkg::ST_RESET:
      begin
        next_arbState = granted ? twa_pkg::ST_IMPLICIT : twa_pkg::ST_EXTERNAL;
      end
      twa_pkg::ST_IMPLICIT, twa_pkg::ST_EXTERNAL:
      begin
        if (!granted)
        begin
          next_arbState = twa_pkg::ST_EXTERNAL;
        end
        else if (coreRequest)
        begin
          // Grant seen at this edge, cycle opens after it
          next_arbState = twa_pkg::ST_EXPLICIT;
          startNow = 1'b1;
        end
        else
        begin
          next_arbState = twa_pkg::ST_IMPLICIT;
        end
      end
      twa_pkg::ST_EXPLICIT:
      begin
        if (!granted && (!inCycle || endOfCycle))
        begin
          next_arbState = twa_pkg::ST_EXTERNAL;
        end
        else if (granted && coreRequest && (!inCycle || endOfCycle) && !coreStart)
        begin
          startNow = 1'b1;
        end
      end
      default:
      begin
        next_arbState = twa_pkg::ST_RESET;
      end
    endcase
  end

  always_comb
  begin
    next_inCycle = inCycle;
    next_beatsLeft = beatsLeft;
    next_addrHold = addrHold;
    next_coreDone = endOfCycle;
    next_coreStart = startNow;
    next_startPinN = twa_pkg::PIN_NEGATED;
    if (endOfCycle)
    begin
      next_inCycle = 1'b0;
    end
    else if (inCycle && isAsserted(link.transferAckN))
    begin
      next_beatsLeft = beatsLeft - 1'b1;
    end
    if (startNow)
    begin
      next_inCycle = 1'b1;
      next_beatsLeft = burstBeats;
      next_addrHold = coreAddr;
      next_startPinN = twa_pkg::PIN_ASSERTED;
    end
    // Request stands until the start; the core may drop it any time
    next_requestN = (coreRequest && !startNow) ? twa_pkg::PIN_ASSERTED : twa_pkg::PIN_NEGATED;
    next_strobePinN = next_inCycle ? twa_pkg::PIN_ASSERTED : twa_pkg::PIN_NEGATED;
    next_drive = (next_arbState == twa_pkg::ST_EXPLICIT);
    next_busyN = next_drive ? twa_pkg::PIN_ASSERTED : twa_pkg::PIN_NEGATED;
  end

  // ----------------------------------------
  // Registers and pins
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arbState <= twa_pkg::ST_RESET;
      inCycle <= 1'b0;
      beatsLeft <= '0;
      addrHold <= '0;
      requestN <= twa_pkg::PIN_NEGATED;
      busyN <= twa_pkg::PIN_NEGATED;
      startPinN <= twa_pkg::PIN_NEGATED;
      strobePinN <= twa_pkg::PIN_NEGATED;
      drive <= 1'b0;
      coreStart <= 1'b0;
      coreDone <= 1'b0;
    end
    else if (watchdogReset)
    begin
      arbState <= twa_pkg::ST_RESET;
      inCycle <= 1'b0;
      beatsLeft <= '0;
      requestN <= twa_pkg::PIN_NEGATED;
      busyN <= twa_pkg::PIN_NEGATED;
      startPinN <= twa_pkg::PIN_NEGATED;
      strobePinN <= twa_pkg::PIN_NEGATED;
      drive <= 1'b0;
      coreStart <= 1'b0;
      coreDone <= 1'b0;
    end
    else
    begin
      arbState <= next_arbState;
      inCycle <= next_inCycle;
      beatsLeft <= next_beatsLeft;
      addrHold <= next_addrHold;
      requestN <= next_requestN;
      busyN <= next_busyN;
      startPinN <= next_startPinN;
      strobePinN <= next_strobePinN;
      drive <= next_drive;
      coreStart <= next_coreStart;
      coreDone <= next_coreDone;
    end
  end

  // Request and busy are never released to high impedance
  assign link.busRequestN = requestN;
  assign link.busBusyN = busyN;
  assign link.transferStartOut = startPinN;
  assign link.transferStartOe = drive;
  assign link.addrStrobeOut = strobePinN;
  assign link.addrStrobeOe = drive;
  assign link.addrOut = addrHold;
  assign link.addrOe = drive;
endmodule

// ---- hdl/twa_link_if.sv ----
// Purpose: Pins between the processor end and the external arbiter end
// Assumes: Strobe and arbitration pins active low, output enables active high, sampled on clk_sys
// Notes: Shared strobes are carried as separate value and output enable signals
`timescale 1ns/10ps
interface twa_link_if;
  // Arbitration pins
  logic busRequestN;
  logic busBusyN;
  logic busGrantN;
  // Shared strobes and address, three-state at the device
  logic transferStartOut;
  logic transferStartOe;
  logic addrStrobeOut;
  logic addrStrobeOe;
  logic [twa_pkg::ADDR_WIDTH-1:0] addrOut;
  logic addrOe;
  // Termination from the addressed slave
  logic transferAckN;

  modport device_end (
    output busRequestN, busBusyN, transferStartOut, transferStartOe,
    output addrStrobeOut, addrStrobeOe, addrOut, addrOe,
    input busGrantN, transferAckN
  );
  modport arbiter_end (
    input busRequestN, busBusyN, transferAckN,
    output busGrantN
  );
endinterface

// ---- hdl/twa_pkg.sv ----
// Purpose: Shared constants and types for the three-wire bus arbitration link
// Assumes: Single clock domain, active-low bus pins
// Notes: Both ends and the interface use these names
package twa_pkg;
  // ----------------------------------------
  // Arbitration states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RESET    = 2'b00,
    ST_IMPLICIT = 2'b01,
    ST_EXPLICIT = 2'b10,
    ST_EXTERNAL = 2'b11
  } twa_state_t;

  // ----------------------------------------
  // Arbiter states
  // ----------------------------------------
  typedef enum logic [1:0] {
    AR_OTHER  = 2'b00,
    AR_GAP    = 2'b01,
    AR_DEVICE = 2'b10
  } twa_arb_t;

  // ----------------------------------------
  // Widths, reset values and timing counts
  // ----------------------------------------
  localparam int ADDR_WIDTH = 32;
  localparam int BEAT_WIDTH = 2;
  localparam logic PIN_NEGATED = 1'b1;
  localparam logic PIN_ASSERTED = 1'b0;
  localparam int GAP_CYCLES = 1;
  localparam int OTHER_HOLD_CYCLES = 4;
endpackage

// ---- sim/three_wire_bus_arbitration_tb_top.sv ----
// Purpose: Bench joining device and arbiter ends
// Assumes: Bench is core, slave and other master
// Notes: Slave acks come from the cycle task
`timescale 1ns/10ps
module three_wire_bus_arbitration_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic watchdogReset = 1'b0;
  logic coreRequest = 1'b0;
  logic [31:0] coreAddr = 32'h0;
  logic [1:0] burstBeats = 2'h0;
  logic busError = 1'b0;
  logic otherRequest = 1'b0;
  logic coreStart, coreDone, otherGrant, deviceGranted;
  twa_pkg::twa_state_t arbState;
  int n_mismatch = 0;
  int check_count = 0;
  // Rows: beats, other master asks mid cycle, bus error, end state
  logic [5:0] rows [6] = '{6'h02, 6'h1b, 6'h32, 6'h2b, 6'h0f, 6'h36};
  twa_link_if link ();
  always #20 clk_sys = ~clk_sys;
  twa_device_end twa_device_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .watchdogReset(watchdogReset),
    .link(link), .coreRequest(coreRequest), .coreAddr(coreAddr), .burstBeats(burstBeats),
    .busError(busError), .coreStart(coreStart), .coreDone(coreDone), .arbState(arbState));
  twa_arbiter_end twa_arbiter_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
    .otherRequest(otherRequest), .otherGrant(otherGrant), .deviceGranted(deviceGranted));
  twa_link_monitor twa_link_monitor_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .busRequestN(link.busRequestN), .busBusyN(link.busBusyN), .busGrantN(link.busGrantN),
    .transferStartOut(link.transferStartOut), .transferStartOe(link.transferStartOe),
    .addrStrobeOut(link.addrStrobeOut), .addrStrobeOe(link.addrStrobeOe), .addrOut(link.addrOut),
    .addrOe(link.addrOe), .transferAckN(link.transferAckN));
  // ----------------
  // Tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tk(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Called at a falling edge; acks follow the start cycle
  task automatic run_cycle(input logic [1:0] beats, input logic other, input logic err,
    input logic [1:0] expSt);
    int n;
    logic fromExt;
    n = 0;
    fromExt = (arbState === twa_pkg::ST_EXTERNAL);
    coreAddr = {30'h0badcafe, beats};
    burstBeats = beats;
    coreRequest = 1'b1;
    while (coreStart !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40)
    begin
      n_mismatch++;
      wrap_up();
    end
    if (!fromExt)
      check(n, 1);
    check({link.busBusyN, link.transferStartOut, link.addrOe}, 3'h1);
    check(link.addrOut, coreAddr);
    coreRequest = 1'b0;
    otherRequest = other;
    for (int i = 0; i <= (err ? 0 : beats); i++)
    begin
      @(negedge clk_sys);
      check(link.busBusyN, 1'b0);
      link.transferAckN = err;
      busError = err;
    end
    @(negedge clk_sys);
    link.transferAckN = 1'b1;
    busError = 1'b0;
    check({coreDone, arbState, link.busBusyN, link.addrOe}, {1'b1, expSt, other, !other});
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    link.transferAckN = 1'b1;
    tk(5);
    check({link.busBusyN, link.busRequestN, link.addrOe, arbState}, {3'h6, twa_pkg::ST_RESET});
    tk(5);
    reset_n = 1'b1;
    tk(12);
    check({arbState, link.busBusyN, link.addrOe}, {twa_pkg::ST_IMPLICIT, 2'h2});
    for (int r = 0; r < 6; r++)
    begin
      otherRequest = 1'b0;
      tk(2);
      run_cycle(rows[r][5:4], rows[r][3], rows[r][2], rows[r][1:0]);
    end
    otherRequest = 1'b1;
    tk(8);
    check({arbState, link.busBusyN, otherGrant, deviceGranted}, {twa_pkg::ST_EXTERNAL, 3'h6});
    coreRequest = 1'b1;
    tk(3);
    check({link.busRequestN, arbState}, {1'b0, twa_pkg::ST_EXTERNAL});
    coreRequest = 1'b0;
    tk(2);
    check(link.busRequestN, 1'b1);
    watchdogReset = 1'b1;
    tk(1);
    check(arbState, twa_pkg::ST_RESET);
    watchdogReset = 1'b0;
    tk(1);
    check(arbState, twa_pkg::ST_EXTERNAL);
    otherRequest = 1'b0;
    tk(12);
    check({arbState, link.busBusyN}, {twa_pkg::ST_IMPLICIT, 1'b1});
    wrap_up();
  end
  initial
  begin
    #(2000 * 40);
    n_mismatch++;
    wrap_up();
  end
endmodule

// ---- sim/twa_link_monitor.sv ----
// Purpose: Link pin checker
// Assumes: Only link pins visible
// Notes: Watchdog reset is not seen here
`timescale 1ns/10ps
module twa_link_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link pins
  input wire logic busRequestN,
  input wire logic busBusyN,
  input wire logic busGrantN,
  input wire logic transferStartOut,
  input wire logic transferStartOe,
  input wire logic addrStrobeOut,
  input wire logic addrStrobeOe,
  input wire logic [twa_pkg::ADDR_WIDTH-1:0] addrOut,
  input wire logic addrOe,
  input wire logic transferAckN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------
  // Sequences
  // ----------------
  sequence s_start;
    !transferStartOut && transferStartOe;
  endsequence
  // Owner with no strobe active means no transfer
  sequence s_idle_owner;
    !busBusyN && transferStartOut && addrStrobeOut;
  endsequence
  // ----------------
  // Properties
  // ----------------
  property p_start_pulse;
    s_start |=> transferStartOut;
  endproperty
  property p_start_granted;
    $fell(busBusyN) |-> !$past(busGrantN);
  endproperty
  property p_start_busy;
    $fell(busBusyN) |-> s_start;
  endproperty
  property p_drive_busy;
    addrOe == !busBusyN && transferStartOe == addrOe && addrStrobeOe == addrOe;
  endproperty
  property p_hold_granted;
    !busBusyN && !busGrantN |=> !busBusyN;
  endproperty
  property p_release_cause;
    $rose(busBusyN) |-> $past(busGrantN);
  endproperty
  property p_idle_release;
    s_idle_owner ##0 busGrantN |=> busBusyN;
  endproperty
  property p_busy_through_start;
    s_start |=> !busBusyN;
  endproperty
  property p_request_dropped;
    s_start |-> busRequestN;
  endproperty
  property p_addr_held;
    !addrStrobeOut && transferStartOut |-> $stable(addrOut);
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start strobe too long");
  a_start_granted: assert property (p_start_granted)
    else $error("busy without grant");
  a_start_busy: assert property (p_start_busy)
    else $error("busy without start");
  a_drive_busy: assert property (p_drive_busy)
    else $error("drive not tied to busy");
  a_hold_granted: assert property (p_hold_granted)
    else $error("busy dropped under grant");
  a_release_cause: assert property (p_release_cause)
    else $error("release while granted");
  a_idle_release: assert property (p_idle_release)
    else $error("idle owner kept bus");
  a_busy_through_start: assert property (p_busy_through_start)
    else $error("bus left mid cycle");
  a_request_dropped: assert property (p_request_dropped)
    else $error("request kept after start");
  a_addr_held: assert property (p_addr_held)
    else $error("address moved in cycle");
endmodule
